// *** rtl/rlom_pkg.sv ***
package rlom_pkg;
  localparam int unsigned CNT_W = 20;
  localparam int unsigned NSTS  = 12;
  localparam logic [3:0]  ROW_LAST  = 4'h8;
  localparam logic [10:0] COL_LAST  = 11'h437;
  localparam logic [3:0]  SLOT_LAST = 4'hb;
  localparam logic [3:0]  SOH_ROWS  = 4'h3;
  localparam logic [10:0] OH_COLS   = 11'h024;
  localparam logic [3:0]  LOH_ROW   = 4'h4;
  localparam logic [3:0]  SYNC_ROW  = 4'h8;
  localparam logic [10:0] B2_COLS   = 11'h00c;
  localparam logic [10:0] K1_COL    = 11'h00c;
  localparam logic [10:0] K2_COL    = 11'h018;
  localparam logic [10:0] S1_COL    = 11'h000;
  localparam logic [10:0] M1_COL    = 11'h01a;
  localparam logic [2:0]  RDI_PAT   = 3'h6;
  localparam logic [2:0]  AIS_PAT   = 3'h7;
  localparam logic [6:0]  FEBE_MAX  = 7'h60;
  localparam logic [6:0]  FEBE_CAP  = 7'h04;
  localparam logic [2:0]  PERS_SHORT = 3'h3;
  localparam logic [2:0]  PERS_LONG  = 3'h5;
  localparam logic [1:0]  K_FILT    = 2'h3;
  localparam logic [3:0]  APS_FAIL_N = 4'hc;
  localparam logic [3:0]  S1_SHORT  = 4'h3;
  localparam logic [3:0]  S1_LONG   = 4'h8;
  localparam logic [7:0]  A_CONFIG  = 8'h00;
  localparam logic [7:0]  A_STATUS  = 8'h04;
  localparam logic [7:0]  A_INT_ST  = 8'h08;
  localparam logic [7:0]  A_INT_EN  = 8'h0c;
  localparam logic [7:0]  A_B2_CNT  = 8'h10;
  localparam logic [7:0]  A_FE_CNT  = 8'h14;
  localparam logic [7:0]  A_K1      = 8'h18;
  localparam logic [7:0]  A_K2      = 8'h1c;
  localparam logic [7:0]  A_S1      = 8'h20;
  localparam logic [7:0]  A_BER_CNT = 8'h24;
  localparam logic [7:0]  A_SF_THR  = 8'h28;
  localparam logic [7:0]  A_SD_THR  = 8'h2c;
  localparam logic [7:0]  A_WIN     = 8'h30;
  localparam int unsigned C_PERS5   = 0;
  localparam int unsigned C_ONE_ERR = 1;
  localparam int unsigned C_B2_WORD = 2;
  localparam int unsigned C_FE_WORD = 3;
  localparam int unsigned C_S1_FILT = 4;
  localparam int unsigned C_S1_LONG = 5;
  localparam int unsigned C_RDI_EN  = 6;
  localparam int unsigned C_AIS_EN  = 7;
  localparam int unsigned C_XFER    = 8;
  localparam logic [7:0]  CFG_RST   = 8'h00;
  localparam logic [15:0] WIN_RST   = 16'h1f40;
  localparam logic [19:0] SF_RST    = 20'hfffff;
  localparam logic [19:0] SD_RST    = 20'hfffff;
endpackage : rlom_pkg

// *** rtl/rlom_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module rlom_top
  import rlom_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic [7:0]  RX_DATA,
  input  wire logic        RX_BYTE_EN,
  input  wire logic        RX_FRAME_START,
  input  wire logic        RX_OOF,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  output var  logic        RX_ALARM,
  output var  logic        LINE_REMOTE_DEFECT,
  output var  logic        LINE_ALARM_INDICATION,
  output var  logic        APS_FAIL,
  output var  logic        IRQ
);
  typedef logic [CNT_W-1:0] rlom_cnt_t;

  function automatic rlom_cnt_t sat_add(input rlom_cnt_t a, input rlom_cnt_t b);
    logic [CNT_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[CNT_W] ? '1 : s[CNT_W-1:0];
  endfunction : sat_add

  function automatic logic [3:0] pop8(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    pop8 = n;
  endfunction : pop8

  // frame position
  logic [3:0]  row, slot, c_row, c_slot, next_row, next_slot;
  logic [10:0] col, c_col, next_col;
  logic        fe, upd, in_line, at_b2, at_k1, at_k2, at_s1, at_m1;
  always_comb begin
    c_row  = RX_FRAME_START ? 4'h0 : row;
    c_col  = RX_FRAME_START ? 11'h000 : col;
    c_slot = RX_FRAME_START ? 4'h0 : slot;
    next_row  = row;
    next_col  = col;
    next_slot = slot;
    if (RX_BYTE_EN) begin
      next_row  = c_row;
      next_col  = c_col + 11'h001;
      next_slot = (c_slot == SLOT_LAST) ? 4'h0 : c_slot + 4'h1;
      if (c_col == COL_LAST) begin
        next_col  = 11'h000;
        next_slot = 4'h0;
        next_row  = (c_row == ROW_LAST) ? 4'h0 : c_row + 4'h1;
      end
    end
    fe      = RX_BYTE_EN && c_row == ROW_LAST && c_col == COL_LAST;
    upd     = fe && !RX_OOF;
    in_line = !(c_row < SOH_ROWS && c_col < OH_COLS);
    at_b2   = RX_BYTE_EN && c_row == LOH_ROW && c_col < B2_COLS;
    at_k1   = RX_BYTE_EN && c_row == LOH_ROW && c_col == K1_COL;
    at_k2   = RX_BYTE_EN && c_row == LOH_ROW && c_col == K2_COL;
    at_s1   = RX_BYTE_EN && c_row == SYNC_ROW && c_col == S1_COL;
    at_m1   = RX_BYTE_EN && c_row == SYNC_ROW && c_col == M1_COL;
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      row  <= 4'h0;
      col  <= 11'h000;
      slot <= 4'h0;
    end else begin
      row  <= next_row;
      col  <= next_col;
      slot <= next_slot;
    end
  end

  logic [7:0] bip_x [NSTS];
  for (genvar s = 0; s < NSTS; s++) begin : g_bip
    logic [7:0] acc, ref_q, next_acc, next_ref;
    always_comb begin
      next_acc = acc;
      next_ref = ref_q;
      if (RX_BYTE_EN && in_line && c_slot == 4'(s)) begin
        next_acc = acc ^ RX_DATA;
      end
      if (fe) begin
        next_ref = next_acc;
        next_acc = 8'h00;
      end
    end
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        acc   <= 8'h00;
        ref_q <= 8'h00;
      end else begin
        acc   <= next_acc;
        ref_q <= next_ref;
      end
    end
    assign bip_x[s] = ref_q ^ RX_DATA;
  end

  // overhead capture and per-frame error sum
  logic       bip_ok, next_bip_ok;
  logic [6:0] ferr, next_ferr;
  logic [7:0] k_now [2];
  logic [7:0] next_k1n, next_k2n, m1_now, next_m1;
  logic [3:0] s1_now, next_s1n;
  always_comb begin
    next_bip_ok = bip_ok | fe;
    next_ferr   = ferr;
    if (at_b2 && bip_ok && !RX_OOF) begin
      next_ferr = ferr + {3'h0, pop8(bip_x[c_slot])};
    end
    if (fe) begin
      next_ferr = 7'h00;
    end
    next_k1n = at_k1 ? RX_DATA : k_now[0];
    next_k2n = at_k2 ? RX_DATA : k_now[1];
    next_s1n = at_s1 ? RX_DATA[3:0] : s1_now;
    next_m1  = at_m1 ? RX_DATA : m1_now;
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      bip_ok   <= 1'b0;
      ferr     <= 7'h00;
      k_now[0] <= 8'h00;
      k_now[1] <= 8'h00;
      s1_now   <= 4'h0;
      m1_now   <= 8'h00;
    end else begin
      bip_ok   <= next_bip_ok;
      ferr     <= next_ferr;
      k_now[0] <= next_k1n;
      k_now[1] <= next_k2n;
      s1_now   <= next_s1n;
      m1_now   <= next_m1;
    end
  end

  // register file and APB slave
  logic [7:0]  cfg, next_cfg;
  logic [1:0]  int_en, next_int_en, int_st, next_int_st, int_set;
  rlom_cnt_t   sf_thr, next_sf_thr, sd_thr, next_sd_thr;
  logic [15:0] win_len, next_win_len;
  logic [31:0] next_prdata, rd_mux;
  logic        next_pready, next_pslverr, acc_ph, done, wr, xfer, ber_rd, unmapped;
  rlom_cnt_t   b2_hold, fe_hold, ber_cnt;
  logic [7:0]  k_cap [2];
  logic [3:0]  s1_cap;
  logic [1:0]  alm;
  logic        aps_fail, sf, sd;
  always_comb begin
    acc_ph   = PSEL && PENABLE;
    done     = acc_ph && PREADY;
    wr       = done && PWRITE;
    unmapped = 1'b0;
    rd_mux   = 32'h0000_0000;
    if (PADDR == A_CONFIG) begin
      rd_mux = {24'h0, cfg};
    end else if (PADDR == A_STATUS) begin
      rd_mux = {27'h0, sd, sf, aps_fail, alm};
    end else if (PADDR == A_INT_ST) begin
      rd_mux = {30'h0, int_st};
    end else if (PADDR == A_INT_EN) begin
      rd_mux = {30'h0, int_en};
    end else if (PADDR == A_B2_CNT) begin
      rd_mux = {12'h0, b2_hold};
    end else if (PADDR == A_FE_CNT) begin
      rd_mux = {12'h0, fe_hold};
    end else if (PADDR == A_K1) begin
      rd_mux = {24'h0, k_cap[0]};
    end else if (PADDR == A_K2) begin
      rd_mux = {24'h0, k_cap[1]};
    end else if (PADDR == A_S1) begin
      rd_mux = {28'h0, s1_cap};
    end else if (PADDR == A_BER_CNT) begin
      rd_mux = {12'h0, ber_cnt};
    end else if (PADDR == A_SF_THR) begin
      rd_mux = {12'h0, sf_thr};
    end else if (PADDR == A_SD_THR) begin
      rd_mux = {12'h0, sd_thr};
    end else if (PADDR == A_WIN) begin
      rd_mux = {16'h0, win_len};
    end else begin
      unmapped = 1'b1;
    end
    next_pready  = acc_ph && !PREADY;
    next_prdata  = (acc_ph && !PREADY) ? rd_mux : PRDATA;
    next_pslverr = acc_ph && !PREADY && unmapped;
    ber_rd = acc_ph && !PREADY && !PWRITE && PADDR == A_BER_CNT;
    // transfer on counter write or initiate bit
    xfer = wr && (PADDR == A_B2_CNT || PADDR == A_FE_CNT ||
                  (PADDR == A_CONFIG && PWDATA[C_XFER]));
    next_cfg     = (wr && PADDR == A_CONFIG) ? PWDATA[7:0] : cfg;
    next_int_en  = (wr && PADDR == A_INT_EN) ? PWDATA[1:0] : int_en;
    next_sf_thr  = (wr && PADDR == A_SF_THR) ? PWDATA[CNT_W-1:0] : sf_thr;
    next_sd_thr  = (wr && PADDR == A_SD_THR) ? PWDATA[CNT_W-1:0] : sd_thr;
    next_win_len = (wr && PADDR == A_WIN) ? PWDATA[15:0] : win_len;
    // set wins over write-one-to-clear
    next_int_st = int_st;
    if (wr && PADDR == A_INT_ST) begin
      next_int_st = int_st & ~PWDATA[1:0];
    end
    next_int_st = next_int_st | int_set;
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      cfg     <= CFG_RST;
      int_en  <= 2'h0;
      int_st  <= 2'h0;
      sf_thr  <= SF_RST;
      sd_thr  <= SD_RST;
      win_len <= WIN_RST;
    end else begin
      PRDATA  <= next_prdata;
      PREADY  <= next_pready;
      PSLVERR <= next_pslverr;
      cfg     <= next_cfg;
      int_en  <= next_int_en;
      int_st  <= next_int_st;
      sf_thr  <= next_sf_thr;
      sd_thr  <= next_sd_thr;
      win_len <= next_win_len;
    end
  end

  // error counters
  rlom_cnt_t  b2_cnt, fe_cnt, next_b2, next_fe, next_ber, next_b2h, next_feh;
  rlom_cnt_t  b2_inc, fe_inc, ber_inc;
  logic [6:0] fe_val;
  always_comb begin
    fe_val = (m1_now[6:0] > FEBE_MAX) ? 7'h00 : m1_now[6:0];
    b2_inc = '0;
    fe_inc = '0;
    ber_inc = '0;
    if (upd && bip_ok) begin
      if (cfg[C_B2_WORD] || cfg[C_ONE_ERR]) begin
        b2_inc = {19'h0, ferr != 7'h00};
      end else begin
        b2_inc = {13'h0, ferr};
      end
      ber_inc = {13'h0, ferr};
    end
    if (upd) begin
      if (cfg[C_FE_WORD]) begin
        fe_inc = {19'h0, fe_val != 7'h00};
      end else begin
        fe_inc = {13'h0, (fe_val > FEBE_CAP) ? FEBE_CAP : fe_val};
      end
    end
    next_b2  = sat_add(xfer ? '0 : b2_cnt, b2_inc);
    next_fe  = sat_add(xfer ? '0 : fe_cnt, fe_inc);
    next_b2h = xfer ? b2_cnt : b2_hold;
    next_feh = xfer ? fe_cnt : fe_hold;
    next_ber = sat_add(ber_rd ? '0 : ber_cnt, ber_inc);
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      b2_cnt  <= '0;
      fe_cnt  <= '0;
      b2_hold <= '0;
      fe_hold <= '0;
      ber_cnt <= '0;
    end else begin
      b2_cnt  <= next_b2;
      fe_cnt  <= next_fe;
      b2_hold <= next_b2h;
      fe_hold <= next_feh;
      ber_cnt <= next_ber;
    end
  end

  logic [2:0] pers_n;
  assign pers_n = cfg[C_PERS5] ? PERS_LONG : PERS_SHORT;
  for (genvar a = 0; a < 2; a++) begin : g_alm
    logic [2:0] cnt, next_cnt;
    logic       match, next_alm;
    always_comb begin
      match    = k_now[1][2:0] == ((a == 0) ? RDI_PAT : AIS_PAT);
      next_cnt = cnt;
      next_alm = alm[a];
      if (upd) begin
        next_cnt = 3'h0;
        if (match != alm[a]) begin
          next_cnt = cnt + 3'h1;
          if (cnt + 3'h1 >= pers_n) begin
            next_cnt = 3'h0;
            next_alm = match;
          end
        end
      end
    end
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        cnt    <= 3'h0;
        alm[a] <= 1'b0;
      end else begin
        cnt    <= next_cnt;
        alm[a] <= next_alm;
      end
    end
  end

  logic [1:0] k_run [2];
  logic [1:0] k_nrun [2];
  for (genvar k = 0; k < 2; k++) begin : g_kf
    logic [7:0] last, next_last, next_cap;
    always_comb begin
      next_last  = last;
      next_cap   = k_cap[k];
      k_nrun[k]  = k_run[k];
      if (upd) begin
        next_last = k_now[k];
        k_nrun[k] = 2'h1;
        if (k_now[k] == last) begin
          k_nrun[k] = (k_run[k] == K_FILT) ? K_FILT : k_run[k] + 2'h1;
        end
        if (k_nrun[k] == K_FILT) begin
          next_cap = k_now[k];
        end
      end
    end
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        last     <= 8'h00;
        k_run[k] <= 2'h0;
        k_cap[k] <= 8'h00;
      end else begin
        last     <= next_last;
        k_run[k] <= k_nrun[k];
        k_cap[k] <= next_cap;
      end
    end
  end

  // protection byte failure, sync nibble, rate window, outputs
  logic [3:0]  nm_cnt, next_nm, s1_run, next_s1run, s1_last, next_s1last, s1_len;
  logic [3:0]  next_s1cap;
  logic        next_aps, next_sf, next_sd, next_alarm, next_irq;
  logic [15:0] win_cnt, next_wcnt;
  rlom_cnt_t   win_err, next_werr, w_tot;
  always_comb begin
    next_nm     = nm_cnt;
    next_aps    = aps_fail;
    next_s1run  = s1_run;
    next_s1last = s1_last;
    next_s1cap  = s1_cap;
    next_wcnt   = win_cnt;
    next_werr   = win_err;
    next_sf     = sf;
    next_sd     = sd;
    int_set     = 2'h0;
    s1_len      = cfg[C_S1_LONG] ? S1_LONG : S1_SHORT;
    w_tot       = sat_add(win_err, ber_inc);
    if (upd) begin
      if (k_nrun[0] == K_FILT) begin
        next_nm  = 4'h0;
        next_aps = 1'b0;
      end else if (nm_cnt != APS_FAIL_N) begin
        next_nm = nm_cnt + 4'h1;
        if (nm_cnt + 4'h1 == APS_FAIL_N) begin
          next_aps = 1'b1;
        end
      end
      next_s1last = s1_now;
      next_s1run  = 4'h1;
      if (s1_now == s1_last) begin
        next_s1run = (s1_run == S1_LONG) ? S1_LONG : s1_run + 4'h1;
      end
      if (!cfg[C_S1_FILT] || next_s1run >= s1_len) begin
        next_s1cap = s1_now;
      end
      next_wcnt = win_cnt + 16'h0001;
      next_werr = w_tot;
      if ({1'b0, win_cnt} + 17'h00001 >= {1'b0, win_len}) begin
        next_wcnt  = 16'h0000;
        next_werr  = '0;
        next_sf    = w_tot >= sf_thr;
        next_sd    = w_tot >= sd_thr;
        int_set[0] = next_sf && !sf;
        int_set[1] = next_sd && !sd;
      end
    end
    next_alarm = (alm[0] && cfg[C_RDI_EN]) || (alm[1] && cfg[C_AIS_EN]);
    next_irq   = |(next_int_st & int_en);
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      nm_cnt   <= 4'h0;
      aps_fail <= 1'b0;
      s1_run   <= 4'h0;
      s1_last  <= 4'h0;
      s1_cap   <= 4'h0;
      win_cnt  <= 16'h0000;
      win_err  <= '0;
      sf       <= 1'b0;
      sd       <= 1'b0;
      RX_ALARM <= 1'b0;
      IRQ      <= 1'b0;
    end else begin
      nm_cnt   <= next_nm;
      aps_fail <= next_aps;
      s1_run   <= next_s1run;
      s1_last  <= next_s1last;
      s1_cap   <= next_s1cap;
      win_cnt  <= next_wcnt;
      win_err  <= next_werr;
      sf       <= next_sf;
      sd       <= next_sd;
      RX_ALARM <= next_alarm;
      IRQ      <= next_irq;
    end
  end
  assign LINE_REMOTE_DEFECT    = alm[0];
  assign LINE_ALARM_INDICATION = alm[1];
  assign APS_FAIL              = aps_fail;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  a_rdi_declare: assert property (upd && !alm[0] && g_alm[0].match &&
    g_alm[0].cnt + 3'h1 == pers_n |=> alm[0]) else $error("remote defect not declared");
  a_ais_clear: assert property (upd && alm[1] && !g_alm[1].match &&
    g_alm[1].cnt + 3'h1 == pers_n |=> !alm[1]) else $error("alarm indication not cleared");
  a_alarm_gate: assert property (RX_ALARM ==
    $past((alm[0] && cfg[C_RDI_EN]) || (alm[1] && cfg[C_AIS_EN])))
    else $error("receive alarm not gated by enables");
  a_febe_illegal: assert property (upd && m1_now[6:0] > FEBE_MAX && !xfer
    |=> $stable(fe_cnt)) else $error("illegal far-end value counted");
  a_febe_cap: assert property (upd && !cfg[C_FE_WORD] && fe_val > FEBE_CAP && !xfer &&
    fe_cnt < 20'hffff0 |=> fe_cnt == $past(fe_cnt) + 20'h00004) else $error("far-end cap wrong");
  a_b2_word: assert property (upd && bip_ok && cfg[C_B2_WORD] && !xfer &&
    b2_cnt < 20'hffff0 |=> b2_cnt == $past(b2_cnt) + {19'h0, $past(ferr) != 7'h00})
    else $error("word mode count wrong");
  a_cnt_sat: assert property (b2_cnt == '1 && !xfer |=> b2_cnt == '1)
    else $error("line counter wrapped");
  a_xfer_hold: assert property (xfer |=> b2_hold == $past(b2_cnt) &&
    fe_hold == $past(fe_cnt) && b2_cnt <= 20'h00060) else $error("transfer latch wrong");
  a_ber_read: assert property (ber_rd |=> PRDATA[19:0] == $past(ber_cnt) && PREADY &&
    ber_cnt <= 20'h00060) else $error("rate counter read wrong");
  a_k_filter: assert property ($changed(k_cap[0]) |-> $past(upd) &&
    $past(k_nrun[0]) == K_FILT) else $error("K1 capture without filter");
  a_aps_raise: assert property ($rose(aps_fail) |-> $past(nm_cnt) + 4'h1 == APS_FAIL_N)
    else $error("byte failure raised early");
  a_aps_clear: assert property (upd && k_nrun[0] == K_FILT |=> !aps_fail)
    else $error("byte failure not cleared");
  a_sd_int: assert property ($rose(sd) |-> int_st[1])
    else $error("degrade crossing without interrupt");
  a_oof_hold: assert property (RX_OOF |=> $stable(alm) && $stable(aps_fail) &&
    $stable(s1_cap)) else $error("detection moved out of frame");
  c_rdi: cover property ($rose(alm[0]));
  c_aps: cover property ($rose(aps_fail));
  c_xfer: cover property (xfer && b2_cnt != '0);
  c_sf: cover property ($rose(sf));
endmodule : rlom_top
`default_nettype wire

// *** dv/rlom_frame_src.sv ***
`timescale 1ns/100ps
`default_nettype none
module rlom_frame_src (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        go,
  input  wire logic [7:0]  k2,
  input  wire logic [3:0]  s1,
  input  wire logic [6:0]  m1,
  input  wire logic [15:0] err,
  output var  logic        busy,
  output var  logic [7:0]  data,
  output var  logic        en,
  output var  logic        fs
);
  int unsigned r;
  int unsigned c;
  logic [7:0]  acc [12];
  logic [7:0]  prv [12];
  logic [7:0]  b;
  always_comb begin
    b = 8'(r * 5 + c);
    // parity of previous frame, flipped on request
    if (r == 4 && c < 12) b = prv[c % 12] ^ (c == 0 ? err[7:0] : c == 1 ? err[15:8] : 8'h00);
    if (r == 4 && c == 12) b = 8'h40 | k2;
    if (r == 4 && c == 24) b = k2;
    if (r == 8 && c == 0) b = {4'ha, s1};
    if (r == 8 && c == 26) b = {1'b1, m1};
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      en <= 1'b0;
      fs <= 1'b0;
      data <= 8'h00;
      r <= 0;
      c <= 0;
      foreach (acc[i]) begin
        acc[i] <= 8'h00;
        prv[i] <= 8'h00;
      end
    end else if (busy) begin
      en <= 1'b1;
      fs <= (r == 0 && c == 0);
      data <= b;
      if (!(r < 3 && c < 36)) acc[c % 12] <= acc[c % 12] ^ b;
      c <= (c == 1079) ? 0 : c + 1;
      if (c == 1079) r <= r + 1;
      if (r == 8 && c == 1079) begin
        busy <= 1'b0;
        foreach (acc[i]) begin
          prv[i] <= (i == 11) ? acc[i] ^ b : acc[i];
          acc[i] <= 8'h00;
        end
      end
    end else begin
      en <= 1'b0;
      fs <= 1'b0;
      // idle bus toggles, never holds a byte
      data <= ~data;
      if (go) begin
        busy <= 1'b1;
        r <= 0;
        c <= 0;
      end
    end
  end
endmodule : rlom_frame_src
`default_nettype wire

// *** dv/test_receive_line_overhead_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_receive_line_overhead_monitor
  import rlom_pkg::*;
;
  logic        clk, resetn, go, psel, penable, pwrite, pready, pslverr, er;
  logic        rx_alarm, rdi, ais, irq, busy, en, fs, oof, aps;
  logic [7:0]  k2, paddr, rx_data;
  logic [3:0]  s1;
  logic [6:0]  m1;
  logic [15:0] err;
  logic [31:0] pwdata, prdata, rd;
  int          n_errors, n_tests, cyc;
  rlom_top i_rlom_top (.CLK(clk), .RESETN(resetn), .RX_DATA(rx_data), .RX_BYTE_EN(en),
    .RX_FRAME_START(fs), .RX_OOF(oof), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_ALARM(rx_alarm), .LINE_REMOTE_DEFECT(rdi), .LINE_ALARM_INDICATION(ais),
    .APS_FAIL(aps), .IRQ(irq));
  rlom_frame_src i_rlom_frame_src (.clk(clk), .resetn(resetn), .go(go), .k2(k2), .s1(s1),
    .m1(m1), .err(err), .busy(busy), .data(rx_data), .en(en), .fs(fs));
  task automatic close_out;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      $display("CHECK FAILED at %0t: no ready from register bus", $time);
    end
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  task automatic flg(input logic [3:0] x);
    chk({28'h0, rx_alarm, ais, rdi, irq}, {28'h0, x});
  endtask : flg
  task automatic frame(input logic [7:0] k, input logic [3:0] s, input logic [6:0] m,
                       input logic [15:0] e);
    @(posedge clk);
    k2 <= k;
    s1 <= s;
    m1 <= m;
    err <= e;
    go <= 1'b1;
    repeat (2) @(posedge clk);
    go <= 1'b0;
    while (busy !== 1'b0) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask : frame
  task automatic t_regs;
    rdc(A_CONFIG, 32'h0);
    rdc(A_WIN, 32'h1f40);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, A_WIN, 32'h1);
    apb(1'b1, A_SF_THR, 32'h3);
    apb(1'b1, A_SD_THR, 32'h2);
    apb(1'b1, A_INT_EN, 32'h3);
    apb(1'b1, A_CONFIG, 32'h40);
    $display("regs done");
  endtask : t_regs
  task automatic t_bits;
    frame(8'h06, 4'h5, 7'h00, 16'h0000);
    frame(8'h06, 4'h5, 7'h0a, 16'h0001);
    flg(4'b0000);
    frame(8'h06, 4'h5, 7'h02, 16'h0103);
    flg(4'b1011);
    rdc(A_INT_ST, 32'h3);
    rdc(A_K2, 32'h06);
    rdc(A_K1, 32'h46);
    rdc(A_S1, 32'h5);
    rdc(A_BER_CNT, 32'h4);
    rdc(A_BER_CNT, 32'h0);
    apb(1'b1, A_B2_CNT, 32'h0);
    rdc(A_B2_CNT, 32'h4);
    rdc(A_FE_CNT, 32'h6);
    apb(1'b1, A_INT_ST, 32'h3);
    rdc(A_STATUS, 32'h19);
    chk({31'h0, irq}, 32'h0);
    $display("bit mode done");
  endtask : t_bits
  task automatic t_words;
    apb(1'b1, A_CONFIG, 32'h5c);
    frame(8'h07, 4'h9, 7'h61, 16'h0000);
    frame(8'h07, 4'h9, 7'h32, 16'h0103);
    flg(4'b1011);
    rdc(A_S1, 32'h5);
    frame(8'h07, 4'h9, 7'h00, 16'h0000);
    flg(4'b0101);
    rdc(A_S1, 32'h9);
    rdc(A_K2, 32'h07);
    apb(1'b1, A_CONFIG, 32'h15c);
    rdc(A_B2_CNT, 32'h1);
    rdc(A_FE_CNT, 32'h1);
    rdc(A_BER_CNT, 32'h3);
    $display("word mode done");
  endtask : t_words
  task automatic t_oof;
    apb(1'b1, A_CONFIG, 32'hcc);
    oof <= 1'b1;
    frame(8'h06, 4'h3, 7'h04, 16'h0001);
    oof <= 1'b0;
    flg(4'b1101);
    chk({31'h0, aps}, 32'h0);
    rdc(A_S1, 32'h9);
    rdc(A_K2, 32'h07);
    rdc(A_BER_CNT, 32'h0);
    $display("out of frame done");
  endtask : t_oof
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 80000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    {resetn, go, psel, penable, pwrite, paddr, pwdata, k2, s1, m1, err, oof} = '0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_bits();
    t_words();
    t_oof();
    close_out();
  end
endmodule : test_receive_line_overhead_monitor
`default_nettype wire
